// ==== logic/ascii_cmd_params.svh ====
// constants for the ascii serial command parser
`ifndef ASCII_CMD_PARAMS_SVH
`define ASCII_CMD_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MCLK_HZ 200000000
`define BAUD_RATE 2400
`define BIT_CYCLES (`MCLK_HZ / `BAUD_RATE)
`define BAUD_CNT_W 17
`define TIMEOUT_S 60
`define TIMEOUT_CYCLES (64'd1 * `MCLK_HZ * `TIMEOUT_S)
`define TMR_W 36

// ----------------------------------------------------------------
// message format
// ----------------------------------------------------------------
`define MAX_IN_LEN 20
`define MAX_OUT_LEN 35
`define CHAR_CR 8'h0D
`define CHAR_EQ 8'h3D
`define CHAR_ZERO 8'h30
`define CHAR_NINE 8'h39
`define CHAR_N 8'h4E
`define CHAR_P 8'h50
`define CHAR_B 8'h42
`define VALUE_SAT 10'h3E7

// ----------------------------------------------------------------
// reply texts
// ----------------------------------------------------------------
`define TOO_LONG_LEN 29
`define INVALID_LEN 16
`define POINTS_LEN 8
`define SAMPLE_LEN 11

// ----------------------------------------------------------------
// settings
// ----------------------------------------------------------------
`define PTS_MIN 7'h02
`define PTS_MAX 7'h14
`define PTS_RESET 7'h14
`define SAMPLE_MIN 7'h01
`define SAMPLE_MAX 7'h50
`define SAMPLE_RESET 7'h01

`endif

// ==== logic/ascii_cmd_pkg.sv ====
// types for the ascii serial command parser
package ascii_cmd_pkg;
  typedef enum {rx_idle, rx_start, rx_data, rx_stop} rx_state_type;
  typedef enum {ctl_collect, ctl_discard, ctl_echo, ctl_resp} ctl_state_type;
  typedef enum {reply_too_long, reply_invalid, reply_points, reply_sample} reply_type;
  typedef logic [7:0] line_type [0:18];
endpackage

// ==== logic/ascii_serial_command_parser.sv ====
// ascii command line front end: uart, line buffer, parser and reply generator
`timescale 1ns/10ps
`include "ascii_cmd_params.svh"

module ascii_serial_command_parser #(
  parameter int unsigned BIT_CYCLES = `BIT_CYCLES,
  parameter logic [`TMR_W-1:0] TIMEOUT_CYCLES = `TMR_W'(`TIMEOUT_CYCLES)
) (
  input wire logic mclk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic rxd, // serial data from host, idles high
  output logic txd, // serial data to host, idles high
  output logic [6:0] point_count, // stored table point count
  output logic [6:0] max_sample_time_setting // stored maximum sample time
);

  localparam logic [`BAUD_CNT_W-1:0] BIT_LAST = `BAUD_CNT_W'(BIT_CYCLES - 1);
  localparam logic [`BAUD_CNT_W-1:0] BIT_HALF = `BAUD_CNT_W'(BIT_CYCLES / 2);

  // ----------------------------------------------------------------
  // reply text lookup
  // ----------------------------------------------------------------
  function automatic logic [4:0] text_len(input ascii_cmd_pkg::reply_type r);
    unique case (r)
      ascii_cmd_pkg::reply_too_long: text_len = 5'(`TOO_LONG_LEN);
      ascii_cmd_pkg::reply_invalid: text_len = 5'(`INVALID_LEN);
      ascii_cmd_pkg::reply_points: text_len = 5'(`POINTS_LEN);
      ascii_cmd_pkg::reply_sample: text_len = 5'(`SAMPLE_LEN);
    endcase
  endfunction

  function automatic logic has_value(input ascii_cmd_pkg::reply_type r);
    has_value = (r == ascii_cmd_pkg::reply_points) || (r == ascii_cmd_pkg::reply_sample);
  endfunction

  function automatic logic [7:0] resp_char(input ascii_cmd_pkg::reply_type r, input logic [4:0] idx,
                                           input logic [3:0] tens, input logic [3:0] ones, input logic two);
    localparam logic [8*`TOO_LONG_LEN-1:0] too_long_text = "Command Sequence is Too Long!";
    localparam logic [8*`INVALID_LEN-1:0] invalid_text = "Invalid Command!";
    localparam logic [8*`POINTS_LEN-1:0] point_count_label = {"NUM P", "TS="};
    localparam logic [8*`SAMPLE_LEN-1:0] sample_label = "MAX M TIME=";
    logic [4:0] k;
    k = idx - text_len(r);
    resp_char = `CHAR_CR;
    if (idx < text_len(r))
    begin
      unique case (r)
        ascii_cmd_pkg::reply_too_long: resp_char = too_long_text[8*(`TOO_LONG_LEN-1-int'(idx)) +: 8];
        ascii_cmd_pkg::reply_invalid: resp_char = invalid_text[8*(`INVALID_LEN-1-int'(idx)) +: 8];
        ascii_cmd_pkg::reply_points: resp_char = point_count_label[8*(`POINTS_LEN-1-int'(idx)) +: 8];
        ascii_cmd_pkg::reply_sample: resp_char = sample_label[8*(`SAMPLE_LEN-1-int'(idx)) +: 8];
      endcase
    end
    else if (has_value(r) && two && k == 5'h00)
      resp_char = `CHAR_ZERO + {4'h0, tens};
    else if (has_value(r) && ((two && k == 5'h01) || (!two && k == 5'h00)))
      resp_char = `CHAR_ZERO + {4'h0, ones};
  endfunction

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  ascii_cmd_pkg::rx_state_type rx_state_q, rx_state_d;
  logic [`BAUD_CNT_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [2:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic [7:0] rx_data_q, rx_data_d;
  logic rx_valid_q, rx_valid_d;

  always_comb
  begin
    rx_state_d = rx_state_q;
    rx_cnt_d = rx_cnt_q - `BAUD_CNT_W'(1);
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    unique case (rx_state_q)
      ascii_cmd_pkg::rx_idle:
      begin
        rx_cnt_d = BIT_HALF;
        if (!rxd)
          rx_state_d = ascii_cmd_pkg::rx_start;
      end
      ascii_cmd_pkg::rx_start:
        if (rx_cnt_q == '0)
        begin
          rx_cnt_d = BIT_LAST;
          rx_bit_d = 3'h0;
          // a start bit gone high by mid-bit was a glitch
          rx_state_d = rxd ? ascii_cmd_pkg::rx_idle : ascii_cmd_pkg::rx_data;
        end
      ascii_cmd_pkg::rx_data:
        if (rx_cnt_q == '0)
        begin
          rx_cnt_d = BIT_LAST;
          rx_sh_d = {rxd, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7)
            rx_state_d = ascii_cmd_pkg::rx_stop;
        end
      ascii_cmd_pkg::rx_stop:
        if (rx_cnt_q == '0)
        begin
          rx_state_d = ascii_cmd_pkg::rx_idle;
          rx_valid_d = rxd;
          rx_data_d = rx_sh_q;
        end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_state_q <= ascii_cmd_pkg::rx_idle;
      rx_cnt_q <= '0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_state_q <= rx_state_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  logic tx_load;
  logic [7:0] tx_char;
  logic tx_busy_q, tx_busy_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [`BAUD_CNT_W-1:0] tx_cnt_q, tx_cnt_d;
  logic txd_q, txd_d;

  always_comb
  begin
    tx_busy_d = tx_busy_q;
    tx_sh_d = tx_sh_q;
    tx_bit_d = tx_bit_q;
    tx_cnt_d = tx_cnt_q;
    txd_d = txd_q;
    if (!tx_busy_q && tx_load)
    begin
      tx_sh_d = {1'b1, tx_char, 1'b0};
      tx_busy_d = 1'b1;
      tx_bit_d = 4'h0;
      tx_cnt_d = BIT_LAST;
      txd_d = 1'b0;
    end
    else if (tx_busy_q)
    begin
      tx_cnt_d = tx_cnt_q - `BAUD_CNT_W'(1);
      if (tx_cnt_q == '0)
      begin
        tx_cnt_d = BIT_LAST;
        tx_bit_d = tx_bit_q + 4'h1;
        tx_sh_d = {1'b1, tx_sh_q[9:1]};
        txd_d = tx_sh_q[1];
        if (tx_bit_q == 4'h9)
        begin
          tx_busy_d = 1'b0;
          txd_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3FF;
      tx_bit_q <= 4'h0;
      tx_cnt_q <= '0;
      txd_q <= 1'b1;
    end
    else
    begin
      tx_busy_q <= tx_busy_d;
      tx_sh_q <= tx_sh_d;
      tx_bit_q <= tx_bit_d;
      tx_cnt_q <= tx_cnt_d;
      txd_q <= txd_d;
    end
  end

  // ----------------------------------------------------------------
  // line buffer, parser and reply sequencing
  // ----------------------------------------------------------------
  ascii_cmd_pkg::ctl_state_type ctl_state_q, ctl_state_d;
  ascii_cmd_pkg::line_type line_q, line_d;
  ascii_cmd_pkg::reply_type reply_q, reply_d;
  logic [4:0] len_q, len_d;
  logic [4:0] idx_q, idx_d;
  logic [3:0] tens_q, tens_d;
  logic [3:0] ones_q, ones_d;
  logic two_q, two_d;
  logic ovl_q, ovl_d;
  logic [`TMR_W-1:0] tmr_q, tmr_d;
  logic [6:0] pts_q, pts_d;
  logic [6:0] sample_time_q, sample_time_d;
  logic [9:0] value;
  logic bad_digit, is_read, is_write, table_point_count_cmd, max_sample_time_cmd;
  logic [6:0] new_value;
  logic [4:0] resp_last;

  always_comb
  begin
    value = 10'h000;
    bad_digit = 1'b0;
    for (int i = 3; i < `MAX_IN_LEN - 1; i++)
      if (5'(i) < len_q)
      begin
        if (line_q[i] < `CHAR_ZERO || line_q[i] > `CHAR_NINE)
          bad_digit = 1'b1;
        // saturate so long digit strings still fail the range check
        value = (value >= 10'h064) ? `VALUE_SAT : 10'(value * 10 + {2'h0, line_q[i] - `CHAR_ZERO});
      end
    table_point_count_cmd = len_q >= 5'h02 && line_q[0] == `CHAR_N && line_q[1] == `CHAR_P;
    max_sample_time_cmd = len_q >= 5'h02 && line_q[0] == `CHAR_N && line_q[1] == `CHAR_B;
    is_read = len_q == 5'h02;
    is_write = len_q >= 5'h04 && line_q[2] == `CHAR_EQ && !bad_digit;
    if (table_point_count_cmd)
      new_value = (is_write && value >= {3'h0, `PTS_MIN} && value <= {3'h0, `PTS_MAX}) ? value[6:0] : pts_q;
    else
      new_value = (is_write && value >= {3'h0, `SAMPLE_MIN} && value <= {3'h0, `SAMPLE_MAX}) ? value[6:0] :
                  sample_time_q;
    resp_last = text_len(reply_q);
    if (has_value(reply_q))
      resp_last = resp_last + (two_q ? 5'h02 : 5'h01);
  end

  always_comb
  begin
    ctl_state_d = ctl_state_q;
    line_d = line_q;
    reply_d = reply_q;
    len_d = len_q;
    idx_d = idx_q;
    tens_d = tens_q;
    ones_d = ones_q;
    two_d = two_q;
    ovl_d = ovl_q;
    pts_d = pts_q;
    sample_time_d = sample_time_q;
    tmr_d = '0;
    tx_load = 1'b0;
    tx_char = `CHAR_CR;
    unique case (ctl_state_q)
      ascii_cmd_pkg::ctl_collect:
        if (rx_valid_q && rx_data_q == `CHAR_CR)
        begin
          ctl_state_d = ascii_cmd_pkg::ctl_echo;
          idx_d = 5'h00;
          tens_d = 4'(new_value / 10);
          ones_d = 4'(new_value % 10);
          two_d = new_value >= 7'h0A;
          if (!(table_point_count_cmd || max_sample_time_cmd) || !(is_read || is_write))
            reply_d = ascii_cmd_pkg::reply_invalid;
          else if (table_point_count_cmd)
          begin
            reply_d = ascii_cmd_pkg::reply_points;
            pts_d = new_value;
          end
          else
          begin
            reply_d = ascii_cmd_pkg::reply_sample;
            sample_time_d = new_value;
          end
        end
        else if (rx_valid_q && len_q == 5'(`MAX_IN_LEN - 1))
        begin
          ctl_state_d = ascii_cmd_pkg::ctl_discard;
          ovl_d = 1'b1;
          len_d = 5'h00;
        end
        else if (rx_valid_q)
        begin
          line_d[len_q] = rx_data_q;
          len_d = len_q + 5'h01;
          tmr_d = tmr_q + `TMR_W'(1);
        end
        else if (len_q != 5'h00 && tmr_q >= TIMEOUT_CYCLES - `TMR_W'(1))
        begin
          ctl_state_d = ascii_cmd_pkg::ctl_discard;
          ovl_d = 1'b0;
          len_d = 5'h00;
        end
        else if (len_q != 5'h00)
          tmr_d = tmr_q + `TMR_W'(1);
      ascii_cmd_pkg::ctl_discard:
        if (rx_valid_q && rx_data_q == `CHAR_CR)
        begin
          reply_d = ascii_cmd_pkg::reply_too_long;
          idx_d = 5'h00;
          ctl_state_d = ovl_q ? ascii_cmd_pkg::ctl_resp : ascii_cmd_pkg::ctl_collect;
        end
      ascii_cmd_pkg::ctl_echo:
      begin
        tx_load = 1'b1;
        tx_char = (idx_q < len_q) ? line_q[idx_q] : `CHAR_CR;
        if (!tx_busy_q)
        begin
          idx_d = idx_q + 5'h01;
          if (idx_q == len_q)
          begin
            ctl_state_d = ascii_cmd_pkg::ctl_resp;
            idx_d = 5'h00;
          end
        end
      end
      ascii_cmd_pkg::ctl_resp:
      begin
        tx_load = 1'b1;
        tx_char = resp_char(reply_q, idx_q, tens_q, ones_q, two_q);
        if (!tx_busy_q)
        begin
          idx_d = idx_q + 5'h01;
          // longest reply is well under the 35 character limit
          if (idx_q == resp_last)
          begin
            ctl_state_d = ascii_cmd_pkg::ctl_collect;
            len_d = 5'h00;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctl_state_q <= ascii_cmd_pkg::ctl_collect;
      for (int i = 0; i < `MAX_IN_LEN - 1; i++)
        line_q[i] <= 8'h00;
      reply_q <= ascii_cmd_pkg::reply_invalid;
      len_q <= 5'h00;
      idx_q <= 5'h00;
      tens_q <= 4'h0;
      ones_q <= 4'h0;
      two_q <= 1'b0;
      ovl_q <= 1'b0;
      tmr_q <= '0;
      pts_q <= `PTS_RESET;
      sample_time_q <= `SAMPLE_RESET;
    end
    else
    begin
      ctl_state_q <= ctl_state_d;
      line_q <= line_d;
      reply_q <= reply_d;
      len_q <= len_d;
      idx_q <= idx_d;
      tens_q <= tens_d;
      ones_q <= ones_d;
      two_q <= two_d;
      ovl_q <= ovl_d;
      tmr_q <= tmr_d;
      pts_q <= pts_d;
      sample_time_q <= sample_time_d;
    end
  end

  assign txd = txd_q;
  assign point_count = pts_q;
  assign max_sample_time_setting = sample_time_q;

endmodule

// ==== tb/parser_checker_props.sv ====
// port assertions for the command parser
`timescale 1ns/10ps
module parser_checker #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic rxd, // serial in
  input wire logic txd, // serial out
  input wire logic [6:0] point_count, // setting
  input wire logic [6:0] max_sample_time_setting // setting
);
  logic prev_q;
  logic prev_d;
  logic [31:0] run_q;
  logic [31:0] run_d;
  always_comb
  begin
    prev_d = txd;
    run_d = (txd != prev_q) ? 32'h1 : run_q + 32'h1;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prev_q <= 1'b1;
      run_q <= 32'h1;
    end
    else
    begin
      prev_q <= prev_d;
      run_q <= run_d;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_rise;
    !prev_q && txd;
  endsequence
  sequence s_fall;
    prev_q && !txd;
  endsequence
  // needs at least 8 cycles per bit
  sequence s_low8;
    !txd [*8];
  endsequence
  a_low_run_bits: assert property (s_rise |-> run_q % BIT_CYCLES == 0 && run_q <= 9 * BIT_CYCLES)
    else $error("low run not whole bits");
  a_high_run_min: assert property (s_fall |-> run_q >= BIT_CYCLES)
    else $error("high run too short");
  a_fall_holds_low: assert property ($fell(txd) |-> s_low8)
    else $error("low bit too short");
  a_reset_values: assert property ($past(rst) |-> point_count == 7'h14 && max_sample_time_setting == 7'h01)
    else $error("bad reset value");
  a_idle_after_reset: assert property ($fell(rst) |-> txd [*8])
    else $error("line not idle after reset");
  a_points_range: assert property (point_count >= 7'h02 && point_count <= 7'h14)
    else $error("point count out of range");
  a_sample_range: assert property (max_sample_time_setting >= 7'h01 && max_sample_time_setting <= 7'h50)
    else $error("sample time out of range");
  a_one_setting: assert property ($changed(point_count) |-> $stable(max_sample_time_setting) && txd)
    else $error("two settings changed at once");
endmodule

bind ascii_serial_command_parser parser_checker #(.BIT_CYCLES(BIT_CYCLES)) i_checker (
  .mclk(mclk), .rst(rst), .rxd(rxd), .txd(txd), .point_count(point_count),
  .max_sample_time_setting(max_sample_time_setting));

// ==== tb/host_uart_model.sv ====
// host terminal model: drives rxd, decodes txd into a byte queue
`timescale 1ns/10ps
module host_uart_model #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  output logic rxd, // toward device
  input wire logic txd // from device
);
  logic [7:0] rx_q [$];
  int frame_errs = 0;
  int line_len = 0;
  int max_len = 0;
  initial rxd = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      #1 rxd = frame[i];
      repeat (BIT_CYCLES - 1) @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
  endtask
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++)
      send_byte(s[i]);
    send_byte(8'h0D);
  endtask
  always
  begin
    logic [7:0] b;
    @(negedge txd);
    if (!rst)
    begin
      repeat (BIT_CYCLES / 2) @(posedge mclk);
      if (txd !== 1'b0) frame_errs++;
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(posedge mclk);
        b[i] = txd;
      end
      repeat (BIT_CYCLES) @(posedge mclk);
      if (txd !== 1'b1) frame_errs++;
      rx_q.push_back(b);
      line_len = (b == 8'h0D) ? 0 : line_len + 1;
      if (line_len > max_len) max_len = line_len;
    end
  end
endmodule

// ==== tb/ascii_serial_command_parser_tb_top.sv ====
// self-checking bench for the ascii serial command parser
`timescale 1ns/10ps
module ascii_serial_command_parser_tb_top;
  localparam int unsigned B = 8;
  // timeout well above a full 20 character line
  localparam logic [35:0] TMO = 36'hFA0;
  localparam string CR = "\015";
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rxd;
  logic txd;
  logic [6:0] point_count;
  logic [6:0] max_sample_time_setting;
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] lfsr_q = 32'hBCA6;
  int exp_v [2] = '{1, 20};
  int lo_v [2] = '{1, 2};
  int hi_v [2] = '{80, 20};
  int corner [2][5] = '{'{0, 1, 81, 80, 2000}, '{1, 2, 21, 20, 0}};
  string bad [6] = '{"XY", {string'("n"), "p"}, {string'("N"), "P", "="}, {string'("N"), "P", "=1A"},
    {string'("N"), "B", "Q"}, {string'("N"), "P", "5"}};
  ascii_serial_command_parser #(.BIT_CYCLES(B), .TIMEOUT_CYCLES(TMO)) i_dut (.mclk(mclk), .rst(rst),
    .rxd(rxd), .txd(txd), .point_count(point_count), .max_sample_time_setting(max_sample_time_setting));
  host_uart_model #(.BIT_CYCLES(B)) i_host (.mclk(mclk), .rst(rst), .rxd(rxd), .txd(txd));
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  function automatic string cmd(input int p);
    return p ? {string'("N"), "P"} : {string'("N"), "B"};
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic string value_reply(input int p);
    string s;
    s = p ? {string'("NUM P"), "TS"} : string'("MAX M TIME");
    return $sformatf("%s=%0d%s", s, exp_v[p], CR);
  endfunction
  task automatic check(input string what, input string seen, input string exp);
    total_checks++;
    if (seen != exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %s seen %s", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic expect_text(input string what, input string exp);
    string seen;
    int k;
    seen = "";
    k = 0;
    while (i_host.rx_q.size() < exp.len() && k < 480 * B)
    begin
      @(posedge mclk);
      k++;
    end
    if (k >= 480 * B)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0d characters seen %0d", what, exp.len(), i_host.rx_q.size());
      conclude();
    end
    else
    begin
      repeat (12 * B) @(posedge mclk);
      while (i_host.rx_q.size() > 0)
        seen = {seen, string'(i_host.rx_q.pop_front())};
      check(what, seen, exp);
      $display("done: %s", what);
    end
  endtask
  task automatic exchange(input string what, input string c);
    i_host.send_line(c);
    expect_text(what, {c, CR, value_reply(c[1] == "P")});
  endtask
  initial
  begin
    int p;
    int v;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    check("pts reset", $sformatf("%0d", point_count), "20");
    check("sample time reset", $sformatf("%0d", max_sample_time_setting), "1");
    exchange("read pts", cmd(1));
    exchange("read sample time", cmd(0));
    for (int i = 0; i < 16; i++)
    begin
      p = i % 2;
      lfsr_q = lfsr_next(lfsr_q);
      v = (i < 10) ? corner[p][i / 2] : int'(lfsr_q % 32'h64);
      if (v >= lo_v[p] && v <= hi_v[p])
        exp_v[p] = v;
      exchange("write", $sformatf("%s=%0d", cmd(p), v));
      check("pts port", $sformatf("%0d", point_count), $sformatf("%0d", exp_v[1]));
      check("sample time port", $sformatf("%0d", max_sample_time_setting), $sformatf("%0d", exp_v[0]));
    end
    foreach (bad[i])
    begin
      i_host.send_line(bad[i]);
      expect_text("invalid", {bad[i], CR, "Invalid Command!", CR});
    end
    i_host.send_line({cmd(1), "=000000000000000001"});
    expect_text("overlength", {"Command Sequence is Too Long!", CR});
    exchange("read after overlength", cmd(1));
    exp_v[1] = 7;
    exchange("longest line", {cmd(1), "=0000000000000007"});
    i_host.send_byte(8'h4E);
    repeat (int'(TMO) + 400) @(posedge mclk);
    i_host.send_line(cmd(0));
    repeat (40 * B) @(posedge mclk);
    check("after timeout", $sformatf("%0d", i_host.rx_q.size()), "0");
    exchange("read after timeout", cmd(0));
    check("tx line length", $sformatf("%0d", i_host.max_len <= 35), "1");
    check("tx framing", $sformatf("%0d", i_host.frame_errs), "0");
    conclude();
  end
endmodule
